// [hw/scb_strap_bank.sv]
/*
  Strap status bank: two read-only registers reporting strap levels caught at
  reset release. Assumes strap inputs are stable while i_srst is high and
  synchronous to i_core_clk.
*/
// Local design decision: the address-and-strobe port.
// Operation
// - bit 15 one shows mirroring strapped on
// - bit 14 one shows downshift strapped on
// - wide package: bit 13 clock output off
// - bit 12 one shows reduced mac interface off
// - bit 10 crossover off, bit 11 zero
// - bit 9 one shows forced pair swap
// - bit 8 one shows half duplex
// - bit 7 one shows autoneg off
// - wide package: bits 6:5 speed choice
// - narrow package: bit 5 speed, 6 zero
// - wide package: bits 4:0 management address
// - narrow package: bits 3:0 address, 4 zero
// - second reg bit 10 quick link loss
// - narrow package: bits 6:4 tx skew
// - narrow package: bits 2:0 rx skew
`timescale 1ns/100ps
`default_nettype none
module scb_strap_bank (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // package variant: 1 = wide (larger package)
  input wire logic i_wide_package,
  // strap levels
  input wire logic i_strap_mirror,
  input wire logic i_strap_downshift,
  input wire logic i_sampled_clock_output_off,
  input wire logic i_sampled_reduced_mac_if_off,
  input wire logic i_sampled_auto_crossover_off,
  input wire logic i_sampled_forced_pair_swap,
  input wire logic i_sampled_half_duplex_on,
  input wire logic i_sampled_autoneg_off,
  input wire logic [1:0] i_sampled_speed_choice_wide,
  input wire logic [4:0] i_sampled_management_address,
  input wire logic i_sampled_quick_link_loss_on,
  input wire logic [2:0] i_strap_tx_skew,
  input wire logic [2:0] i_strap_rx_skew,
  // register port
  input wire logic [scb_pkg::SCB_ADDR_W-1:0] i_addr,
  input wire logic [scb_pkg::SCB_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [scb_pkg::SCB_DATA_W-1:0] o_rdata,
  // latched image valid
  output logic o_straps_valid
);
  import scb_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic in_reset;
    logic valid;
    logic [15:0] sts_one;
    logic [15:0] sts_two;
    logic [15:0] rdata;
  } scb_state_t;

  scb_state_t st;
  scb_state_t next_st;
  logic [15:0] img_one;
  logic [15:0] img_two;

  // ----------------------------------------
  // register images built from live straps
  // ----------------------------------------
  always_comb begin
    img_one = SCB_RESET_VALUE;
    img_one[SCB_B_MIRROR] = i_strap_mirror;
    img_one[SCB_B_DOWNSHIFT] = i_strap_downshift;
    img_one[SCB_B_CLKOUT_OFF] = i_wide_package & i_sampled_clock_output_off;
    img_one[SCB_B_RMAC_OFF] = i_sampled_reduced_mac_if_off;
    img_one[SCB_B_XOVER_OFF] = i_sampled_auto_crossover_off;
    img_one[SCB_B_PAIR_SWAP] = i_sampled_forced_pair_swap;
    img_one[SCB_B_HALF_DUP] = i_sampled_half_duplex_on;
    img_one[SCB_B_ANEG_OFF] = i_sampled_autoneg_off;
    if (i_wide_package) begin
      img_one[SCB_B_SPEED_LO +: 2] = i_sampled_speed_choice_wide;
      img_one[SCB_B_ADDR_LO +: 5] = i_sampled_management_address;
    end else begin
      // narrow package uses only the low speed bit and four address bits
      img_one[SCB_B_SPEED_LO] = i_sampled_speed_choice_wide[0];
      img_one[SCB_B_ADDR_LO +: 4] = i_sampled_management_address[3:0];
    end
    img_two = SCB_RESET_VALUE;
    img_two[SCB_B_QLL] = i_sampled_quick_link_loss_on;
    if (!i_wide_package) begin
      img_two[SCB_B_TXSKEW_LO +: 3] = i_strap_tx_skew;
      img_two[SCB_B_RXSKEW_LO +: 3] = i_strap_rx_skew;
    end
  end

  // ----------------------------------------
  // read decode
  // ----------------------------------------
  // one decoder for the live image on the capture edge and the held image later
  function automatic logic [SCB_DATA_W-1:0] f_select(
    input logic [SCB_ADDR_W-1:0] addr,
    input logic [SCB_DATA_W-1:0] one,
    input logic [SCB_DATA_W-1:0] two
  );
    logic [SCB_DATA_W-1:0] word;
    word = SCB_RESET_VALUE;
    case (addr)
      SCB_OFS_STS_ONE: begin
        word = one;
      end
      SCB_OFS_STS_TWO: begin
        word = two;
      end
      default: begin
        word = SCB_RESET_VALUE;
      end
    endcase
    return word;
  endfunction

  // ----------------------------------------
  // capture and read path
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.rdata = SCB_RESET_VALUE;
    // caught on the first edge after release, so the reset itself only loads constants
    if (st.in_reset) begin
      next_st.sts_one = img_one;
      next_st.sts_two = img_two;
      next_st.valid = 1'b1;
      next_st.in_reset = 1'b0;
    end
    if (i_rd) begin
      if (st.in_reset) begin
        next_st.rdata = f_select(i_addr, img_one, img_two);
      end else begin
        next_st.rdata = f_select(i_addr, st.sts_one, st.sts_two);
      end
    end
    // i_wr and i_wdata deliberately touch nothing: both registers are read-only
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st <= '0;
      st.in_reset <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_straps_valid = st.valid;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // capture edge: reset already low, image not yet taken
  sequence s_capture;
    !i_srst && st.in_reset;
  endsequence
  sequence s_capture_wide;
    !i_srst && st.in_reset && i_wide_package;
  endsequence
  sequence s_capture_narrow;
    !i_srst && st.in_reset && !i_wide_package;
  endsequence
  sequence s_read_one;
    i_rd && i_addr == SCB_OFS_STS_ONE;
  endsequence
  sequence s_read_two;
    i_rd && i_addr == SCB_OFS_STS_TWO;
  endsequence
  sequence s_read_other;
    i_rd && i_addr != SCB_OFS_STS_ONE && i_addr != SCB_OFS_STS_TWO;
  endsequence
  sequence s_idle;
    !i_rd;
  endsequence

  chk_hold_stable: assert property (@(posedge i_core_clk) disable iff (i_srst)
    st.valid && $past(st.valid) |-> $stable(st.sts_one) && $stable(st.sts_two))
    else $error("strap image changed after capture");
  chk_write_ignored: assert property (@(posedge i_core_clk) disable iff (i_srst)
    st.valid && i_wr ##1 1'b1 |-> $stable(st.sts_one))
    else $error("write altered strap image");
  chk_reserved_one: assert property (@(posedge i_core_clk) disable iff (i_srst)
    st.sts_one[11] == 1'b0)
    else $error("reserved bit 11 set");
  chk_reserved_two: assert property (@(posedge i_core_clk) disable iff (i_srst)
    st.sts_two[15:11] == 5'h00 && st.sts_two[9:7] == 3'h0)
    else $error("reserved high bits set");
  chk_rx_bit3: assert property (@(posedge i_core_clk) disable iff (i_srst)
    st.sts_two[3] == 1'b0)
    else $error("bit 3 of second register set");
  chk_narrow_res: assert property (@(posedge i_core_clk) disable iff (i_srst)
    st.valid && !i_wide_package |-> st.sts_one[4] == 1'b0 && st.sts_one[6] == 1'b0)
    else $error("narrow reserved bits set");
  chk_wide_skew: assert property (@(posedge i_core_clk) disable iff (i_srst)
    st.valid && i_wide_package |-> st.sts_two[6:4] == 3'h0 && st.sts_two[2:0] == 3'h0)
    else $error("wide package skew bits set");
  chk_read_one: assert property (@(posedge i_core_clk) disable iff (i_srst)
    st.valid && i_rd && i_addr == SCB_OFS_STS_ONE |=> o_rdata == st.sts_one)
    else $error("first register read mismatch");
  chk_capture: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_capture |=> st.valid && st.sts_one == $past(img_one)
      && st.sts_two == $past(img_two))
    else $error("capture did not take strap image");

  // ----------------------------------------
  // field capture against the pins
  // ----------------------------------------
  chk_cap_mirror: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_capture
      |=> st.sts_one[SCB_B_MIRROR] == $past(i_strap_mirror))
    else $error("mirror field not captured");
  chk_cap_downshift: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_capture
      |=> st.sts_one[SCB_B_DOWNSHIFT] == $past(i_strap_downshift))
    else $error("downshift field not captured");
  chk_cap_clkout: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_capture
      |=> st.sts_one[SCB_B_CLKOUT_OFF] == ($past(i_wide_package) && $past(i_sampled_clock_output_off)))
    else $error("clock output field not captured");
  chk_cap_mac_off: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_capture
      |=> st.sts_one[SCB_B_RMAC_OFF] == $past(i_sampled_reduced_mac_if_off))
    else $error("mac interface field not captured");
  chk_cap_xover: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_capture
      |=> st.sts_one[SCB_B_XOVER_OFF] == $past(i_sampled_auto_crossover_off))
    else $error("crossover field not captured");
  chk_cap_pair_swap: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_capture
      |=> st.sts_one[SCB_B_PAIR_SWAP] == $past(i_sampled_forced_pair_swap))
    else $error("pair swap field not captured");
  chk_cap_duplex: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_capture
      |=> st.sts_one[SCB_B_HALF_DUP] == $past(i_sampled_half_duplex_on))
    else $error("duplex field not captured");
  chk_cap_autoneg: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_capture
      |=> st.sts_one[SCB_B_ANEG_OFF] == $past(i_sampled_autoneg_off))
    else $error("autoneg field not captured");
  chk_cap_speed_wide: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_capture_wide
      |=> st.sts_one[SCB_B_SPEED_LO +: 2] == $past(i_sampled_speed_choice_wide))
    else $error("wide speed field not captured");
  chk_cap_speed_narrow: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_capture_narrow
      |=> st.sts_one[SCB_B_SPEED_LO] == $past(i_sampled_speed_choice_wide[0]) && !st.sts_one[SCB_B_SPEED_LO + 1])
    else $error("narrow speed field not captured");
  chk_cap_addr_wide: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_capture_wide
      |=> st.sts_one[SCB_B_ADDR_LO +: 5] == $past(i_sampled_management_address))
    else $error("wide address field not captured");
  chk_cap_addr_narrow: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_capture_narrow
      |=> st.sts_one[SCB_B_ADDR_LO +: 4] == $past(i_sampled_management_address[3:0]) && !st.sts_one[SCB_B_ADDR_LO + 4])
    else $error("narrow address field not captured");
  chk_cap_quick_loss: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_capture
      |=> st.sts_two[SCB_B_QLL] == $past(i_sampled_quick_link_loss_on))
    else $error("quick link loss field not captured");
  chk_cap_tx_skew: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_capture_narrow
      |=> st.sts_two[SCB_B_TXSKEW_LO +: 3] == $past(i_strap_tx_skew))
    else $error("tx skew field not captured");
  chk_cap_rx_skew: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_capture_narrow
      |=> st.sts_two[SCB_B_RXSKEW_LO +: 3] == $past(i_strap_rx_skew))
    else $error("rx skew field not captured");

  // ----------------------------------------
  // read port and reset
  // ----------------------------------------
  chk_read_two: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_read_two
      |=> o_rdata == st.sts_two)
    else $error("second register read mismatch");
  chk_read_other: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_read_other
      |=> o_rdata == SCB_RESET_VALUE)
    else $error("unmapped read not zero");
  chk_read_pulse: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_idle
      |=> o_rdata == SCB_RESET_VALUE)
    else $error("read data stood past its cycle");
  chk_read_live: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_capture ##0 s_read_one
      |=> o_rdata[SCB_B_MIRROR] == $past(i_strap_mirror) && o_rdata[SCB_B_DOWNSHIFT] == $past(i_strap_downshift))
    else $error("read on capture edge missed live straps");
  chk_reset_clear: assert property (@(posedge i_core_clk)
    i_srst
      |=> !o_straps_valid && o_rdata == SCB_RESET_VALUE)
    else $error("reset left image or read data");
  chk_valid_late: assert property (@(posedge i_core_clk) disable iff (i_srst)
    s_capture
      |-> !o_straps_valid)
    else $error("valid raised before capture");
  chk_valid_hold: assert property (@(posedge i_core_clk) disable iff (i_srst)
    o_straps_valid
      |=> o_straps_valid)
    else $error("valid dropped without reset");
  chk_write_two: assert property (@(posedge i_core_clk) disable iff (i_srst)
    st.valid && i_wr
      |=> $stable(st.sts_two))
    else $error("write altered second image");
endmodule
`default_nettype wire

// [include/scb_pkg.sv]
/*
  Constants for the strap status bank: register offsets, field positions, widths.
  Assumes a 16-bit management register port with one-cycle read latency.
*/
package scb_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] SCB_OFS_STS_ONE = 8'h6E;
  localparam logic [7:0] SCB_OFS_STS_TWO = 8'h6F;
  localparam int SCB_ADDR_W = 8;
  localparam int SCB_DATA_W = 16;
  // ----------------------------------------
  // first register fields
  // ----------------------------------------
  localparam int SCB_B_MIRROR = 15;
  localparam int SCB_B_DOWNSHIFT = 14;
  localparam int SCB_B_CLKOUT_OFF = 13;
  localparam int SCB_B_RMAC_OFF = 12;
  localparam int SCB_B_XOVER_OFF = 10;
  localparam int SCB_B_PAIR_SWAP = 9;
  localparam int SCB_B_HALF_DUP = 8;
  localparam int SCB_B_ANEG_OFF = 7;
  localparam int SCB_B_SPEED_LO = 5;
  localparam int SCB_B_ADDR_LO = 0;
  // ----------------------------------------
  // second register fields
  // ----------------------------------------
  localparam int SCB_B_QLL = 10;
  localparam int SCB_B_TXSKEW_LO = 4;
  localparam int SCB_B_RXSKEW_LO = 0;
  localparam logic [15:0] SCB_RESET_VALUE = 16'h0000;
endpackage

// [verif/scb_strap_model.sv]
/*
  Board strap model: resistors holding each strap pin at a fixed level.
  Assumes the bench picks the levels; pull resistors never float, so no released state.
*/
`timescale 1ns/100ps
`default_nettype none
module scb_strap_model (
  // levels fitted on the board
  input wire logic [21:0] i_levels,
  // strap pins seen by the bank
  output logic [21:0] o_straps
);
  assign o_straps = i_levels;
endmodule
`default_nettype wire

// [verif/scb_strap_bank_tb.sv]
/*
  Bench for the strap status bank: one row per strap pattern and package.
  Assumes the one-cycle read port and straps caught at reset release.
*/
`timescale 1ns/100ps
`default_nettype none
module scb_strap_bank_tb;
  import scb_pkg::*;
  typedef struct packed {logic w; logic [21:0] lv; logic [15:0] e1; logic [15:0] e2;} scb_row_t;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wide = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [21:0] lv = 22'h000000;
  logic [21:0] s;
  logic [15:0] rdata;
  logic valid;
  int failures = 0;
  int n_tests = 0;
  scb_row_t rows [4] = '{'{1'b1, 22'h3FFFFF, 16'hF7FF, 16'h0400}, '{1'b0, 22'h3FFFFF, 16'hD7AF, 16'h0477},
    '{1'b1, 22'h155555, 16'hA535, 16'h0000}, '{1'b0, 22'h2AAAAA, 16'h528A, 16'h0425}};
  always #25 clk = ~clk;
  scb_strap_model u_model (.i_levels(lv), .o_straps(s));
  scb_strap_bank u_dut (.i_core_clk(clk), .i_srst(srst), .i_wide_package(wide),
    .i_strap_mirror(s[0]), .i_strap_downshift(s[1]), .i_sampled_clock_output_off(s[2]),
    .i_sampled_reduced_mac_if_off(s[3]), .i_sampled_auto_crossover_off(s[4]),
    .i_sampled_forced_pair_swap(s[5]), .i_sampled_half_duplex_on(s[6]), .i_sampled_autoneg_off(s[7]),
    .i_sampled_speed_choice_wide(s[9:8]), .i_sampled_management_address(s[14:10]),
    .i_sampled_quick_link_loss_on(s[15]), .i_strap_tx_skew(s[18:16]), .i_strap_rx_skew(s[21:19]),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_straps_valid(valid));
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk) rd <= 1'b1;
    addr <= a;
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic wr_one(input logic [7:0] a);
    @(posedge clk) wr <= 1'b1;
    addr <= a;
    wdata <= 16'hFFFF;
    @(posedge clk) wr <= 1'b0;
  endtask
  // ----------------------------------------
  // verdict
  // ----------------------------------------
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #20000 failures++;
    results();
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) srst <= 1'b1;
      wide <= rows[i].w;
      lv <= rows[i].lv;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rd_chk(SCB_OFS_STS_ONE, rows[i].e1);
      rd_chk(SCB_OFS_STS_TWO, rows[i].e2);
      chk({15'h0000, valid}, 16'h0001);
      // pins move after capture and both registers are written
      @(posedge clk) lv <= ~rows[i].lv;
      wr_one(SCB_OFS_STS_ONE);
      wr_one(SCB_OFS_STS_TWO);
      rd_chk(SCB_OFS_STS_ONE, rows[i].e1);
      rd_chk(SCB_OFS_STS_TWO, rows[i].e2);
      rd_chk(8'h70, 16'h0000);
    end
    // second reset mid-run: image dropped until release
    @(posedge clk) srst <= 1'b1;
    rd_chk(SCB_OFS_STS_ONE, 16'h0000);
    chk({15'h0000, valid}, 16'h0000);
    // release with a read on the capturing edge: live pins, then the new image holds
    @(posedge clk) srst <= 1'b0;
    rd <= 1'b1;
    addr <= SCB_OFS_STS_ONE;
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata, 16'h8525);
    chk({15'h0000, valid}, 16'h0001);
    rd_chk(SCB_OFS_STS_TWO, 16'h0052);
    results();
  end
endmodule
`default_nettype wire
